//--- hcsc_consts.vh
// Constants for the Hall commutation and speed calculation block
`ifndef HCSC_CONSTS_VH
`define HCSC_CONSTS_VH

// ==========================================================
// Register byte offsets
`define HCSC_OFS_CTRL      8'h00
`define HCSC_OFS_SCALE     8'h04
`define HCSC_OFS_KP        8'h08
`define HCSC_OFS_KI        8'h0C
`define HCSC_OFS_SPEED     8'h10
`define HCSC_OFS_REV       8'h14
`define HCSC_OFS_SECTOR    8'h18
`define HCSC_OFS_PHASE     8'h1C
`define HCSC_TABLE_BIT     7

// ==========================================================
// Control fields and reset values
`define HCSC_CTRL_EN       0
`define HCSC_CTRL_DIR      1
`define HCSC_CTRL_SECTOR   2
`define HCSC_CTRL_RST      3'h0
`define HCSC_SCALE_RST     32'h00000000
`define HCSC_GAIN_RST      32'h00000000

// ==========================================================
// Fixed-point limits (1.23)
`define HCSC_FRAC_MAX      24'h7FFFFF
`define HCSC_FRAC_MIN      24'h800000

// ==========================================================
// Command word fields
`define HCSC_CMD_CH_LSB    0
`define HCSC_CMD_BASE_LSB  8
`define HCSC_CMD_COMP_LSB  16
`define HCSC_CMD_OPT_LSB   24
`define HCSC_OPT_NEG_BIT   24

// ==========================================================
// Channel states
`define HCSC_ST_ON_HIGH    2'h0
`define HCSC_ST_ON_LOW     2'h1
`define HCSC_ST_OFF_LOW    2'h2
`define HCSC_ST_OFF_HIGH   2'h3

// ==========================================================
// Timing
`define HCSC_CLK_HZ        125000000
`define HCSC_TB_HZ         1000000
`define HCSC_TB_DIV        (`HCSC_CLK_HZ / `HCSC_TB_HZ)
`define HCSC_SECTORS       6

`endif

//--- hcsc_core.v
// Hall commutation, speed calculation and gain scaling logic
//
// Chosen here: the register offsets and the plain strobed port.
`include "hcsc_consts.vh"

module hcsc_core #(
   parameter TB_DIV  = `HCSC_TB_DIV,
   parameter PER_W   = 24
) (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire [2:0]  i_hall,
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   output reg  [5:0]  o_base_state,
   output reg  [5:0]  o_comp_state,
   output reg  [2:0]  o_option_invert_duty_sign,
   output reg  [23:0] o_speed,
   output reg         o_speed_valid,
   output reg  [23:0] o_kp,
   output reg         o_kp_wide,
   output reg  [23:0] o_ki,
   output reg         o_ki_wide
);

   localparam S_IDLE = 2'h0;
   localparam S_OFF  = 2'h1;
   localparam S_ON   = 2'h2;
   localparam REV_W  = PER_W + 3;
   localparam [PER_W-1:0] PER_MAX = {PER_W{1'b1}};

   // ==========================================================
   // Gain conversion
   // Fits 1.23 when the nine integer bits are pure sign extension
   function [24:0] gain_conv;
      input [31:0] g;
      begin
         if (g[31:23] == {9{g[31]}} )
            gain_conv = {1'b0, g[23:0]};
         else
            gain_conv = {1'b1, g[31:8]};
      end
   endfunction

   // Off-state test of a 2-bit channel state
   function is_off;
      input [1:0] st;
      begin
         is_off = st[1];
      end
   endfunction

   // ==========================================================
   // Registers
   reg [2:0]        ctrl_ff;
   reg [31:0]       scale_ff;
   reg [31:0]       kp_raw_ff;
   reg [31:0]       ki_raw_ff;
   reg [31:0]       cmd_mem [0:31];
   reg [2:0]        pend_neg_ff;
   reg [2:0]        hall_prev_ff;
   reg [6:0]        tb_div_ff;
   reg              tb_tick_ff;
   reg [PER_W-1:0]  sect_cnt_ff;
   reg [PER_W-1:0]  sect_ring_ff [0:5];
   reg [2:0]        ring_ptr_ff;
   reg [PER_W-1:0]  sector_ff;
   reg [REV_W-1:0]  rev_ff;
   reg [1:0]        seq_ff;
   reg [3:0]        seq_idx_ff;
   reg              div_busy_ff;
   reg              div_req_ff;
   reg [5:0]        div_cnt_ff;
   reg [31:0]       div_num_ff;
   reg [31:0]       div_quo_ff;
   reg [REV_W:0]    div_rem_ff;
   reg [REV_W-1:0]  div_den_ff;
   integer          k;
   integer          j;                 // Reset loop index, apart from the sum loop

   wire [2:0]       hall_chg = i_hall ^ hall_prev_ff;
   wire             hall_evt = (hall_chg != 3'h0) & ctrl_ff[`HCSC_CTRL_EN];
   reg  [1:0]       evt_ph;
   reg  [REV_W-1:0] nxt_rev;

   // Lowest changed Hall phase picks the table entry
   always @* begin
      if (hall_chg[0])
         evt_ph = 2'h0;
      else if (hall_chg[1])
         evt_ph = 2'h1;
      else
         evt_ph = 2'h2;
   end

   // ==========================================================
   // Register writes
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_ff   <= `HCSC_CTRL_RST;
         scale_ff  <= `HCSC_SCALE_RST;
         kp_raw_ff <= `HCSC_GAIN_RST;
         ki_raw_ff <= `HCSC_GAIN_RST;
      end else if (i_wr && !i_addr[`HCSC_TABLE_BIT]) begin
         case (i_addr)
            `HCSC_OFS_CTRL:  ctrl_ff   <= i_wdata[2:0];
            `HCSC_OFS_SCALE: scale_ff  <= i_wdata;
            `HCSC_OFS_KP:    kp_raw_ff <= i_wdata;
            `HCSC_OFS_KI:    ki_raw_ff <= i_wdata;
            default: ;
         endcase
      end
   end

   // Command table; memory without reset, software fills it first
   always @(posedge i_sys_clk) begin
      if (i_wr && i_addr[`HCSC_TABLE_BIT])
         cmd_mem[i_addr[6:2]] <= i_wdata;
   end

   // ==========================================================
   // Read data, valid only in the cycle after the strobe
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h00000000;
      end else if (i_rd) begin
         if (i_addr[`HCSC_TABLE_BIT]) begin
            o_rdata <= cmd_mem[i_addr[6:2]];
         end else begin
            case (i_addr)
               `HCSC_OFS_CTRL:   o_rdata <= {29'h0, ctrl_ff};
               `HCSC_OFS_SCALE:  o_rdata <= scale_ff;
               `HCSC_OFS_KP:     o_rdata <= kp_raw_ff;
               `HCSC_OFS_KI:     o_rdata <= ki_raw_ff;
               `HCSC_OFS_SPEED:  o_rdata <= {8'h00, o_speed};
               `HCSC_OFS_REV:    o_rdata <= {{(32-REV_W){1'b0}}, rev_ff};
               `HCSC_OFS_SECTOR: o_rdata <= {{(32-PER_W){1'b0}}, sector_ff};
               `HCSC_OFS_PHASE:  o_rdata <= {5'h00, pend_neg_ff, 5'h00, o_option_invert_duty_sign,
                                             2'h0, o_comp_state, 2'h0, o_base_state};
               default:          o_rdata <= 32'h00000000;
            endcase
         end
      end else begin
         o_rdata <= 32'h00000000;
      end
   end

   // ==========================================================
   // Gain outputs, refreshed every cycle from the raw registers
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_kp      <= 24'h000000;
         o_kp_wide <= 1'b0;
         o_ki      <= 24'h000000;
         o_ki_wide <= 1'b0;
      end else begin
         {o_kp_wide, o_kp} <= gain_conv(kp_raw_ff);
         {o_ki_wide, o_ki} <= gain_conv(ki_raw_ff);
      end
   end

   // ==========================================================
   // Timebase divider and sector period measurement
   // Sector counter saturates so a stalled motor reads as slowest speed
   always @* begin
      nxt_rev = {{(REV_W-PER_W){1'b0}}, sect_cnt_ff};
      for (k = 0; k < `HCSC_SECTORS; k = k + 1) begin
         if (k[2:0] != ring_ptr_ff)
            nxt_rev = nxt_rev + {{(REV_W-PER_W){1'b0}}, sect_ring_ff[k]};
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tb_div_ff    <= 7'h00;
         tb_tick_ff   <= 1'b0;
         sect_cnt_ff  <= {PER_W{1'b0}};
         ring_ptr_ff  <= 3'h0;
         sector_ff    <= {PER_W{1'b0}};
         rev_ff       <= {REV_W{1'b0}};
         hall_prev_ff <= 3'h0;
         for (j = 0; j < `HCSC_SECTORS; j = j + 1)
            sect_ring_ff[j] <= {PER_W{1'b0}};
      end else begin
         hall_prev_ff <= i_hall;
         tb_tick_ff   <= (tb_div_ff == TB_DIV - 1);
         tb_div_ff    <= (tb_div_ff == TB_DIV - 1) ? 7'h00 : tb_div_ff + 7'h01;
         if (hall_evt) begin
            sector_ff                 <= sect_cnt_ff;
            sect_ring_ff[ring_ptr_ff] <= sect_cnt_ff;
            rev_ff                    <= nxt_rev;
            ring_ptr_ff <= (ring_ptr_ff == 3'h5) ? 3'h0 : ring_ptr_ff + 3'h1;
            sect_cnt_ff <= {PER_W{1'b0}};
         end else if (tb_tick_ff && sect_cnt_ff != PER_MAX) begin
            sect_cnt_ff <= sect_cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================
   // Speed divider: one quotient bit per cycle, 32 cycles
   // A transition during a division is remembered and rerun after it
   wire [REV_W:0] div_try = {div_rem_ff[REV_W-1:0], div_num_ff[31]};
   wire           div_ge  = (div_try >= {1'b0, div_den_ff});
   wire [REV_W-1:0] sect6 = {1'b0, sector_ff, 2'b00} + {2'b00, sector_ff, 1'b0};

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         div_busy_ff   <= 1'b0;
         div_req_ff    <= 1'b0;
         div_cnt_ff    <= 6'h00;
         div_num_ff    <= 32'h00000000;
         div_quo_ff    <= 32'h00000000;
         div_rem_ff    <= {(REV_W+1){1'b0}};
         div_den_ff    <= {REV_W{1'b0}};
         o_speed       <= 24'h000000;
         o_speed_valid <= 1'b0;
      end else begin
         o_speed_valid <= 1'b0;
         if (hall_evt)
            div_req_ff <= 1'b1;
         if (!div_busy_ff && div_req_ff && !hall_evt) begin
            div_req_ff  <= 1'b0;
            div_busy_ff <= 1'b1;
            div_cnt_ff  <= 6'h00;
            div_num_ff  <= scale_ff;
            div_quo_ff  <= 32'h00000000;
            div_rem_ff  <= {(REV_W+1){1'b0}};
            // Sector mode scales by six to keep the same full scale
            div_den_ff  <= ctrl_ff[`HCSC_CTRL_SECTOR] ? sect6 : rev_ff;
         end else if (div_busy_ff) begin
            div_num_ff <= {div_num_ff[30:0], 1'b0};
            div_rem_ff <= div_ge ? div_try - {1'b0, div_den_ff} : div_try;
            div_quo_ff <= {div_quo_ff[30:0], div_ge};
            div_cnt_ff <= div_cnt_ff + 6'h01;
            if (div_cnt_ff == 6'h1F) begin
               div_busy_ff   <= 1'b0;
               o_speed_valid <= 1'b1;
               // Zero period or overflow clamps to full scale
               if (div_den_ff == {REV_W{1'b0}} ||
                   {div_quo_ff[30:0], div_ge} > {8'h00, `HCSC_FRAC_MAX})
                  o_speed <= `HCSC_FRAC_MAX;
               else
                  o_speed <= {div_quo_ff[22:0], div_ge};
            end
         end
      end
   end

   // ==========================================================
   // Commutation sequencer: off command, then on command
   wire [31:0] cmd_word = cmd_mem[{seq_idx_ff, seq_ff == S_ON}];
   wire [1:0]  cmd_ph   = cmd_word[`HCSC_CMD_CH_LSB +: 2];
   wire [1:0]  cmd_base = cmd_word[`HCSC_CMD_BASE_LSB +: 2];
   wire [1:0]  cmd_comp = cmd_word[`HCSC_CMD_COMP_LSB +: 2];
   wire        cmd_neg  = cmd_word[`HCSC_OPT_NEG_BIT];

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         seq_ff       <= S_IDLE;
         seq_idx_ff   <= 4'h0;
         o_base_state <= {3{`HCSC_ST_OFF_LOW}};
         o_comp_state <= {3{`HCSC_ST_OFF_LOW}};
         o_option_invert_duty_sign   <= 3'h0;
         pend_neg_ff  <= 3'h0;
      end else begin
         case (seq_ff)
            S_IDLE: begin
               if (hall_evt) begin
                  seq_idx_ff <= {ctrl_ff[`HCSC_CTRL_DIR], evt_ph, i_hall[evt_ph]};
                  seq_ff     <= S_OFF;
               end
            end
            S_OFF, S_ON: begin
               if (cmd_ph != 2'h3) begin
                  o_base_state[cmd_ph*2 +: 2] <= cmd_base;
                  o_comp_state[cmd_ph*2 +: 2] <= cmd_comp;
                  if (is_off(cmd_base)) begin
                     pend_neg_ff[cmd_ph] <= cmd_neg;
                  end else begin
                     o_option_invert_duty_sign[cmd_ph]  <= cmd_neg;
                     pend_neg_ff[cmd_ph] <= cmd_neg;
                  end
               end
               seq_ff <= (seq_ff == S_OFF) ? S_ON : S_IDLE;
            end
            default: seq_ff <= S_IDLE;
         endcase
      end
   end

endmodule

//--- hcsc_hall_model.sv
// Hall sensor model: three-bit code stepping around a six-state ring
module hcsc_hall_model (
   input  logic       i_sys_clk,
   input  logic       i_rst,
   input  logic       i_step,
   input  logic       i_rev,
   output logic [2:0] o_hall
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pos_ff;
   // Ring position to Hall code
   function automatic logic [2:0] ring_code(input logic [2:0] p);
      case (p)
         3'h0:    ring_code = 3'h4;
         3'h1:    ring_code = 3'h5;
         3'h2:    ring_code = 3'h1;
         3'h3:    ring_code = 3'h3;
         3'h4:    ring_code = 3'h2;
         default: ring_code = 3'h6;
      endcase
   endfunction
   // Only one bit moves per step, as on a real sensor ring
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst)
         pos_ff <= 3'h0;
      else if (i_step && i_rev)
         pos_ff <= (pos_ff == 3'h0) ? 3'h5 : pos_ff - 3'h1;
      else if (i_step)
         pos_ff <= (pos_ff == 3'h5) ? 3'h0 : pos_ff + 3'h1;
   end
   assign o_hall = ring_code(pos_ff);
endmodule

//--- hcsc_core_sva.sv
// Port checker for the Hall commutation and speed block
module hcsc_core_sva #(
   parameter TB_DIV = 125,
   parameter PER_W  = 24
) (
   input wire        i_sys_clk,
   input wire        i_rst,
   input wire [2:0]  i_hall,
   input wire [7:0]  i_addr,
   input wire [31:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [31:0] o_rdata,
   input wire [5:0]  o_base_state,
   input wire [5:0]  o_comp_state,
   input wire [2:0]  o_option_invert_duty_sign,
   input wire [23:0] o_speed,
   input wire        o_speed_valid,
   input wire [23:0] o_kp,
   input wire        o_kp_wide,
   input wire [23:0] o_ki,
   input wire        o_ki_wide
);
   reg  [31:0] kp_ff;
   reg  [31:0] ki_ff;
   wire        kp_big;
   wire        ki_big;
   // Last gain words; 9.15 is needed once the top nine bits stop matching the sign
   always @(posedge i_sys_clk) begin
      if (i_wr && i_addr == 8'h08)
         kp_ff <= i_wdata;
      if (i_wr && i_addr == 8'h0C)
         ki_ff <= i_wdata;
   end
   assign kp_big = !(&kp_ff[31:23] || ~|kp_ff[31:23]);
   assign ki_big = !(&ki_ff[31:23] || ~|ki_ff[31:23]);
   default clocking dc @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Speed result
   speed_range_a: assert property (o_speed <= 24'h7FFFFF)
      else $error("speed above full scale");
   speed_read_a: assert property (i_rd && i_addr == 8'h10 |=> o_rdata[31:23] == 9'h000)
      else $error("speed read not a positive fraction");
   valid_pulse_a: assert property (o_speed_valid |=> !o_speed_valid)
      else $error("speed valid longer than one cycle");
   speed_update_a: assert property ($changed(o_speed) |-> o_speed_valid)
      else $error("speed changed without valid");
   // ==========================================================
   // Gain conversion, allowing up to two cycles of latency
   kp_conv_a: assert property (i_wr && i_addr == 8'h08 |-> ##[1:2]
      (o_kp_wide == kp_big && o_kp == (kp_big ? kp_ff[31:8] : kp_ff[23:0])))
      else $error("proportional gain converted wrongly");
   ki_conv_a: assert property (i_wr && i_addr == 8'h0C |-> ##[1:2]
      (o_ki_wide == ki_big && o_ki == (ki_big ? ki_ff[31:8] : ki_ff[23:0])))
      else $error("integral gain converted wrongly");
   // ==========================================================
   // Commutation timing against the Hall change
   comm_order_a: assert property ($changed(o_base_state) || $changed(o_comp_state) |->
      $past(i_hall, 2) != $past(i_hall, 3) || $past(i_hall, 3) != $past(i_hall, 4))
      else $error("phase state moved without a Hall change");
   neg_timing_a: assert property ($changed(o_option_invert_duty_sign) |->
      $past(i_hall, 3) != $past(i_hall, 4))
      else $error("duty sign moved outside a switch-on");
endmodule

bind hcsc_core hcsc_core_sva #(.TB_DIV(TB_DIV), .PER_W(PER_W)) hcsc_core_sva_i (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hall(i_hall), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_base_state(o_base_state), .o_comp_state(o_comp_state), .o_option_invert_duty_sign(o_option_invert_duty_sign),
   .o_speed(o_speed), .o_speed_valid(o_speed_valid), .o_kp(o_kp), .o_kp_wide(o_kp_wide),
   .o_ki(o_ki), .o_ki_wide(o_ki_wide));

//--- tb.sv
// Self-checking bench for the Hall commutation and speed block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_sys_clk = 1'b0;
   logic        i_rst     = 1'b1;
   logic [7:0]  i_addr    = 8'h00;
   logic [31:0] i_wdata   = 32'h00000000;
   logic        i_wr      = 1'b0;
   logic        i_rd      = 1'b0;
   logic        step      = 1'b0;
   logic        rev       = 1'b0;
   wire  [2:0]  i_hall;
   wire  [31:0] o_rdata;
   wire  [5:0]  o_base_state;
   wire  [5:0]  o_comp_state;
   wire  [2:0]  o_option_invert_duty_sign;
   wire  [23:0] o_speed;
   wire  [23:0] o_kp;
   wire  [23:0] o_ki;
   wire         o_speed_valid;
   wire         o_kp_wide;
   wire         o_ki_wide;
   int          errors  = 0;
   int          n_tests = 0;

   always #4 i_sys_clk = ~i_sys_clk;

   // Short timebase divider keeps the speed runs brief
   hcsc_core #(.TB_DIV(4)) hcsc_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hall(i_hall),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_base_state(o_base_state), .o_comp_state(o_comp_state), .o_option_invert_duty_sign(o_option_invert_duty_sign),
      .o_speed(o_speed), .o_speed_valid(o_speed_valid), .o_kp(o_kp), .o_kp_wide(o_kp_wide),
      .o_ki(o_ki), .o_ki_wide(o_ki_wide));
   hcsc_hall_model hcsc_hall_model_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_step(step),
      .i_rev(rev), .o_hall(i_hall));

   // ==========================================================
   // Access tasks; each starts on an edge so no strobe is driven twice in a step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      chk(o_rdata, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
   endtask
   task automatic turn(input logic d);
      @(posedge i_sys_clk);
      step <= 1'b1;
      rev <= d;
      @(posedge i_sys_clk);
      step <= 1'b0;
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rd(8'h1C, 32'h00002A2A);
      rd(8'h20, 32'h00000000);
      wr(8'h10, 32'h00123456);
      rd(8'h10, 32'h00000000);
      wr(8'h08, 32'h00400000);
      wr(8'h0C, 32'h02000000);
      settle(2);
      chk({7'h00, o_kp_wide, o_kp}, 32'h00400000);
      chk({7'h00, o_ki_wide, o_ki}, 32'h01020000);
      wr(8'h08, 32'hFF800000);
      settle(2);
      chk({7'h00, o_kp_wide, o_kp}, 32'h00800000);
      for (int k = 0; k < 32; k++) wr(8'h80 + 8'(k * 4), 32'h00000003);
      // Rising phase A forward: B to off-high with pending negate, then A on
      wr(8'h88, 32'h01020301);
      wr(8'h8C, 32'h01010000);
      wr(8'h00, 32'h00000001);
      turn(1'b0);
      // Off command shows two edges after the Hall step, the on command one later
      settle(2);
      chk({26'h0000000, o_base_state}, 32'h0000002E);
      settle(1);
      // The on command records its own option as pending as well
      rd(8'h1C, 32'h0301292C);
      // Falling phase A backward: A off keeps its old sign until switched on
      wr(8'h00, 32'h00000003);
      wr(8'hC0, 32'h00020200);
      wr(8'hC4, 32'h00010001);
      turn(1'b1);
      settle(6);
      chk({17'h00000, o_option_invert_duty_sign, o_comp_state, o_base_state}, 32'h000019A2);
      // Steady 40-cycle sectors give 10 ticks each, 60 per revolution;
      // the Hall steps stay off the tick edge, else a tick is lost to the restart
      wr(8'h00, 32'h00000001);
      wr(8'h04, 32'h00000258);
      for (int k = 0; k < 8; k++) begin
         turn(1'b0);
         settle(38);
      end
      chk({8'h00, o_speed}, 32'h0000000A);
      rd(8'h14, 32'h0000003C);
      rd(8'h18, 32'h0000000A);
      wr(8'h04, 32'hFFFFFFFF);
      turn(1'b0);
      settle(38);
      chk({8'h00, o_speed}, 32'h007FFFFF);
      wr(8'h00, 32'h00000005);
      wr(8'h04, 32'h000004B0);
      for (int k = 0; k < 2; k++) begin
         turn(1'b0);
         settle(38);
      end
      rd(8'h10, 32'h00000014);
      tally_and_finish();
   end

   // Watchdog well beyond the roughly 570 cycles the sequence needs
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
